// ==== rtl/serial_port_defs.svh ====
// constants for the write-only serial display port
// assumes inclusion by bare name from package and modules
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH
// ==========================================
// framing
`define WORD_BITS 8
`define NINE_BITS 9
`define CNT_W 4
// ==========================================
// host clock divider: link clock half period in core cycles
`define HALF_PERIOD_NS 32
`define CORE_PERIOD_NS 8
`define HALF_CYCLES ((`HALF_PERIOD_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define DIV_W 4
`endif

// ==== rtl/serial_port_pkg.sv ====
// types shared by both ends of the serial write port
// assumes serial_port_defs.svh on the include path
`include "serial_port_defs.svh"
package serial_port_pkg;
   // one received or sent word: destination flag and byte
   typedef struct packed {
      logic is_data;
      logic [`WORD_BITS-1:0] byte_val;
   } word_t;
   typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} host_state_t;
endpackage

// ==== rtl/serial_link_if.sv ====
// link between host and display port: select, clock, data, c/d
// assumes the bench instantiates it and joins both ends
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
   logic select_bar;
   logic sclk;
   logic serial_in_pin;
   logic cmd_data;
   modport host (output select_bar, output sclk, output serial_in_pin, output cmd_data);
   modport device (input select_bar, input sclk, input serial_in_pin, input cmd_data);
endinterface
`default_nettype wire

// ==== rtl/epd_host_serial_write_port.sv ====
// device end: receives serial words, routes them to command or ram
// assumes sclk stands still outside frames and core_clk is free running
`include "serial_port_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - strap high four wire, low nine bit
// - four wire: c/d line picks destination
// - eight bits shifted msb first
// - byte handed on its final clock edge
// - write only, data never driven back
// - three wire: flag then eight bits
// - flag one ram, zero command
// - c/d pin ignored in three wire
// - host keeps select low whole word
// - activity ignored while select high
// - active low reset clears interface
module epd_host_serial_write_port (
   // link side
   serial_link_if.device link,
   input wire logic hw_reset_n,
   input wire logic interface_strap,
   // core side
   input wire logic core_clk,
   input wire logic resetn,
   output logic word_valid,
   output logic word_is_data,
   output logic [`WORD_BITS-1:0] word_byte,
   input wire logic word_ready,
   output logic word_dropped
);
   // ==========================================
   // link domain, clocked by sclk
   typedef struct packed {
      logic [`CNT_W-1:0] cnt;
      logic flag;
      logic [`WORD_BITS-1:0] sh;
      serial_port_pkg::word_t word;
      logic tgl;
   } link_st_t;
   link_st_t l_q, l_d;
   logic sel_rst_n;
   logic [`WORD_BITS-1:0] sh_next;
   assign sel_rst_n = hw_reset_n & ~link.select_bar;
   assign sh_next = {l_q.sh[`WORD_BITS-2:0], link.serial_in_pin};

   // bit counting; select high holds l_q in reset, not the word copy
   always_comb begin
      l_d = l_q;
      l_d.cnt = l_q.cnt + 4'h1;
      if (interface_strap) begin
         l_d.sh = sh_next;
         if (l_q.cnt == 4'(`WORD_BITS - 1)) begin
            l_d.cnt = 4'h0;
            l_d.word.is_data = link.cmd_data;
            l_d.word.byte_val = sh_next;
            l_d.tgl = ~l_q.tgl;
         end
      end else begin
         // cmd_data is never read here: the pin is ignored
         if (l_q.cnt == 4'h0) begin
            l_d.flag = link.serial_in_pin;
         end else begin
            l_d.sh = sh_next;
         end
         if (l_q.cnt == 4'(`NINE_BITS - 1)) begin
            l_d.cnt = 4'h0;
            l_d.word.is_data = l_q.flag;
            l_d.word.byte_val = sh_next;
            l_d.tgl = ~l_q.tgl;
         end
      end
   end

   // toggle kept outside the select reset so a finished word is not lost
   logic word_tgl_q;
   serial_port_pkg::word_t word_hold_q;
   always_ff @(posedge link.sclk or negedge sel_rst_n) begin
      if (!sel_rst_n) begin
         l_q.cnt <= 4'h0;
         l_q.flag <= 1'b0;
         l_q.sh <= 8'h00;
         l_q.word <= 9'h000;
         l_q.tgl <= 1'b0;
      end else begin
         l_q <= l_d;
      end
   end
   // lasting copies of word and event, reset only by the pin
   logic last_tgl;
   assign last_tgl = l_q.tgl;
   always_ff @(posedge link.sclk or negedge hw_reset_n) begin
      if (!hw_reset_n) begin
         word_tgl_q <= 1'b0;
         word_hold_q <= 9'h000;
      end else if (l_d.tgl != last_tgl) begin
         word_tgl_q <= ~word_tgl_q;
         word_hold_q <= l_d.word;
      end
   end

   // ==========================================
   // core domain: toggle sync, two entry buffer
   typedef struct packed {
      logic [2:0] sync;
      serial_port_pkg::word_t [1:0] mem;
      logic wp;
      logic rp;
      logic [1:0] count;
      logic valid;
      serial_port_pkg::word_t out;
      logic dropped;
   } core_st_t;
   core_st_t c_q, c_d;
   logic take, push, pop, full;

   // word_hold is stable for many sclk periods after the toggle moves
   always_comb begin
      c_d = c_q;
      c_d.sync = {c_q.sync[1:0], word_tgl_q};
      push = c_q.sync[2] != c_q.sync[1];
      pop = c_q.valid & word_ready;
      take = (c_q.count != 2'd0) & (~c_q.valid | pop);
      // output register is one of the two entries, so full is two words in all
      full = (c_q.count == 2'd2) | ((c_q.count != 2'd0) & c_q.valid);
      c_d.dropped = push & full & ~take;
      if (take) begin
         c_d.out = c_q.mem[c_q.rp];
         c_d.rp = ~c_q.rp;
      end
      if (push & ~c_d.dropped) begin
         c_d.mem[c_q.wp] = word_hold_q;
         c_d.wp = ~c_q.wp;
      end
      c_d.count = c_q.count + 2'(push & ~c_d.dropped) - 2'(take);
      c_d.valid = take | (c_q.valid & ~pop);
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         c_q <= '0;
      end else begin
         c_q <= c_d;
      end
   end

   assign word_valid = c_q.valid;
   assign word_is_data = c_q.out.is_data;
   assign word_byte = c_q.out.byte_val;
   assign word_dropped = c_q.dropped;
   // no output toward the data line exists at all

   // ==========================================
   // operating notes
   // link side
   // - bits are taken only on rising sclk with select low
   // - select high holds counter, shift and flag in reset
   // - so a cut frame leaves nothing behind for the next one
   // - the finished word copy sits outside that reset
   // - reason: select may rise right after the last bit
   // - strap is read straight in the sclk domain
   // - limitation: sclk stands still between frames, so a
   //   synchroniser there would lag by two bits; the strap
   //   must therefore be settled before select falls
   // - in nine bit framing the c/d pin is never looked at
   // - in four wire framing c/d is taken at the last rise
   // - the host must keep c/d steady through that rise
   //
   // crossing
   // - one toggle per finished word, moved in the sclk domain
   // - the core side sees it through a three stage chain
   // - only the second and third stages are compared
   // - the word copy is not synchronised bit by bit
   // - it is safe because it stands for a whole frame after
   //   the toggle moves, far longer than the chain delay
   // - trade-off: a next word must not finish within about
   //   three core cycles of the last one; a host that keeps
   //   one idle half period between frames meets that easily
   //
   // buffer
   // - two words in all: one in the output register, one in
   //   the memory behind it
   // - a word that arrives while both are held is lost
   // - the loss is shown by a one cycle pulse on word_dropped
   // - the older words are kept; the newest one is dropped
   // - word_valid and the word stand until word_ready is seen
   // - a pop and a push in one cycle never count as full
   //
   // reset
   // - resetn clears the core side only
   // - hw_reset_n clears the whole link side
   // - both are asynchronous and active low
   // - after both together, the first word needs a fresh frame; either alone, with the toggle left high, yields a word without one
   //
   // hazards for users
   // - a glitch on select inside a frame drops the word
   // - extra sclk rises with select low shift in junk bits
   // - no read path exists; the data pin is input only
   // - the port never stalls the host; watch word_dropped
   // - the destination flag travels with its byte, so a
   //   command and the data after it cannot be swapped
endmodule // epd_host_serial_write_port
`default_nettype wire

// ==== rtl/serial_write_host.sv ====
// host end: sends command or data words over the serial link
// assumes core_clk free running; sclk is divided from it
`include "serial_port_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_write_host (
   // link side
   serial_link_if.host link,
   // core side
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic three_wire,
   input wire logic req_valid,
   input wire logic req_is_data,
   input wire logic [`WORD_BITS-1:0] req_byte,
   output logic req_ready
);
   typedef struct packed {
      serial_port_pkg::host_state_t st;
      logic [`DIV_W-1:0] div;
      logic [`CNT_W-1:0] bits;
      logic [`NINE_BITS-1:0] sh;
      logic sel_b;
      logic clk;
      logic dat;
      logic cd;
      logic rdy;
   } host_st_t;
   host_st_t q, d;
   logic tick;

   // data changes on falling sclk, device samples on rising
   always_comb begin
      d = q;
      tick = q.div == 4'(`HALF_CYCLES - 1);
      d.div = tick ? 4'h0 : q.div + 4'h1;
      d.rdy = 1'b0;
      case (q.st)
         serial_port_pkg::H_IDLE: begin
            d.div = 4'h0;
            d.sel_b = 1'b1;
            d.clk = 1'b0;
            d.rdy = 1'b1;
            if (req_valid & q.rdy) begin
               d.rdy = 1'b0;
               d.st = serial_port_pkg::H_SHIFT;
               d.sel_b = 1'b0;
               d.cd = three_wire ? 1'b0 : req_is_data;
               d.sh = three_wire ? {req_is_data, req_byte} : {req_byte, 1'b0};
               d.bits = three_wire ? 4'(`NINE_BITS) : 4'(`WORD_BITS);
               d.dat = three_wire ? req_is_data : req_byte[`WORD_BITS-1];
            end
         end
         serial_port_pkg::H_SHIFT: begin
            if (tick) begin
               d.clk = ~q.clk;
               if (q.clk) begin
                  d.sh = {q.sh[`NINE_BITS-2:0], 1'b0};
                  d.dat = q.sh[`NINE_BITS-2];
                  if (q.bits == 4'h1) begin
                     d.st = serial_port_pkg::H_GAP;
                  end
                  d.bits = q.bits - 4'h1;
               end
            end
         end
         serial_port_pkg::H_GAP: begin
            if (tick) begin
               d.sel_b = 1'b1;
               d.st = serial_port_pkg::H_IDLE;
            end
         end
         default: d.st = serial_port_pkg::H_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.sel_b <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign link.select_bar = q.sel_b;
   assign link.sclk = q.clk;
   assign link.serial_in_pin = q.dat;
   assign link.cmd_data = q.cd;
   assign req_ready = q.rdy;
endmodule // serial_write_host
`default_nettype wire

// ==== test/serial_port_asserts.sv ====
// checker for the link joining host and display port
// assumes tb instantiates it beside the link interface
`include "serial_port_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_port_asserts (
   // core domain
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic three_wire,
   // link
   input wire logic select_bar,
   input wire logic sclk,
   input wire logic serial_in_pin,
   input wire logic cmd_data,
   // device core side
   input wire logic word_valid,
   input wire logic word_ready,
   input wire logic word_is_data,
   input wire logic [`WORD_BITS-1:0] word_byte,
   input wire logic word_dropped
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   // rising sclk edges per frame, cleared while deselected
   logic sclk_q;
   logic [3:0] rises_q;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sclk_q <= 1'h0;
         rises_q <= 4'h0;
      end else begin
         sclk_q <= sclk;
         rises_q <= select_bar ? 4'h0 : rises_q + {3'h0, sclk & ~sclk_q};
      end
   end
   // ==========================================
   // link behaviour
   property p_idle_clk; select_bar |-> !sclk; endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("sclk moves while deselected");
   property p_half; $rose(sclk) |=> sclk [*3]; endproperty
   a_half: assert property (p_half) else $error("sclk high phase short");
   property p_data_hold; sclk |-> $stable(serial_in_pin); endproperty
   a_data_hold: assert property (p_data_hold) else $error("data moved while sclk high");
   property p_cd_hold; !select_bar && !$fell(select_bar) |-> $stable(cmd_data); endproperty
   a_cd_hold: assert property (p_cd_hold) else $error("c/d moved inside frame");
   property p_count; $rose(select_bar) |-> rises_q == (three_wire ? 4'h9 : 4'h8); endproperty
   a_count: assert property (p_count) else $error("wrong bit count in frame");
   property p_gap; $rose(select_bar) |-> !$past(sclk, 1) && !$past(sclk, 3); endproperty
   a_gap: assert property (p_gap) else $error("select released too early");
   // device core side
   property p_hold; word_valid && !word_ready |=> word_valid && $stable({word_is_data, word_byte}); endproperty
   a_hold: assert property (p_hold) else $error("word changed while stalled");
   property p_answer;
      (!select_bar && sclk && !sclk_q && rises_q == (three_wire ? 4'h8 : 4'h7)) |->
         ##[1:8] (word_valid || word_dropped);
   endproperty
   a_answer: assert property (p_answer) else $error("word not delivered");
   property p_drop; word_dropped |-> word_valid && !$past(word_ready); endproperty
   a_drop: assert property (p_drop) else $error("drop without full buffer");
   // main scenarios
   c_four: cover property ($rose(select_bar) && !three_wire);
   c_nine: cover property ($rose(select_bar) && three_wire);
   c_drop: cover property (word_dropped);
endmodule // serial_port_asserts
`default_nettype wire

// ==== test/tb.sv ====
// bench: host end and display port joined by the link
// assumes rtl and checker compiled first
`include "serial_port_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic core_clk = 1'h0;
   logic resetn = 1'h0;
   logic strap = 1'h1;
   logic three_wire = 1'h0;
   logic req_valid = 1'h0;
   logic req_is_data = 1'h0;
   logic [`WORD_BITS-1:0] req_byte = 8'h00;
   logic word_ready = 1'h0;
   logic req_ready, word_valid, word_is_data, word_dropped;
   logic [`WORD_BITS-1:0] word_byte;
   int errors = 0;
   int check_count = 0;
   int drops = 0;
   // rows: {three_wire, is_data, byte}
   logic [9:0] rows [8] = '{10'h080, 10'h101, 10'h201, 10'h380, 10'h3FF, 10'h000, 10'h1A5, 10'h25A};
   serial_link_if link ();
   serial_write_host i_serial_write_host (.link(link.host), .core_clk(core_clk), .resetn(resetn),
      .three_wire(three_wire), .req_valid(req_valid), .req_is_data(req_is_data), .req_byte(req_byte),
      .req_ready(req_ready));
   epd_host_serial_write_port i_epd_host_serial_write_port (.link(link.device), .hw_reset_n(resetn),
      .interface_strap(strap), .core_clk(core_clk), .resetn(resetn), .word_valid(word_valid),
      .word_is_data(word_is_data), .word_byte(word_byte), .word_ready(word_ready), .word_dropped(word_dropped));
   serial_port_asserts i_serial_port_asserts (.core_clk(core_clk), .resetn(resetn), .three_wire(three_wire),
      .select_bar(link.select_bar), .sclk(link.sclk), .serial_in_pin(link.serial_in_pin),
      .cmd_data(link.cmd_data), .word_valid(word_valid), .word_ready(word_ready),
      .word_is_data(word_is_data), .word_byte(word_byte), .word_dropped(word_dropped));
   // clock and drop pulse counter, sampled mid cycle
   always #4 core_clk = ~core_clk;
   always @(negedge core_clk) if (word_dropped === 1'h1) drops++;
   // ==========================================
   // tasks
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // mode only changes once the host is idle, so a frame never sees it move
   task automatic send(input logic [9:0] row);
      int n;
      for (n = 0; n < 300 && req_ready !== 1'h1; n++) @(negedge core_clk);
      if (n == 300) begin
         errors++;
         conclude();
      end
      three_wire = row[9];
      strap = ~row[9];
      req_is_data = row[8];
      req_byte = row[7:0];
      req_valid = 1'h1;
      @(negedge core_clk);
      req_valid = 1'h0;
   endtask
   task automatic recv(input logic [8:0] exp);
      int n;
      for (n = 0; n < 300 && word_valid !== 1'h1; n++) @(negedge core_clk);
      if (n == 300) begin
         errors++;
         conclude();
      end
      chk({word_is_data, word_byte}, exp);
      word_ready = 1'h1;
      @(negedge core_clk);
      word_ready = 1'h0;
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (12) @(negedge core_clk);
      chk({word_valid, link.select_bar, link.sclk, 6'h00}, 9'h080);
      resetn = 1'h1;
      for (int i = 0; i < 8; i++) begin
         send(rows[i]);
         recv(rows[i][8:0]);
      end
      $display("table of words done");
      // receiver stalls: two words kept, third lost
      send(10'h011);
      send(10'h122);
      send(10'h033);
      for (int n = 0; n < 300 && drops == 0; n++) @(negedge core_clk);
      chk(9'(drops), 9'h001);
      recv(9'h011);
      recv(9'h122);
      chk({8'h00, word_valid}, 9'h000);
      $display("stall test done");
      // reset in mid frame, then a clean word
      send(10'h2C3);
      repeat (20) @(negedge core_clk);
      resetn = 1'h0;
      @(negedge core_clk);
      chk({word_valid, link.select_bar, 7'h00}, 9'h080);
      resetn = 1'h1;
      send(10'h13C);
      recv(9'h13C);
      $display("reset test done");
      conclude();
   end
endmodule // tb
`default_nettype wire
